/* qmtu_pkg.sv */
// Shared constants and types for the quad-mode timer unit.
`default_nettype none
package qmtu_pkg;
    // =====================================================================
    // Sizes
    localparam int QMTU_NUM_TIMERS = 3;
    localparam int QMTU_WIDTH = 32;
    localparam int QMTU_WDOG_INDEX = 2;
    // =====================================================================
    // Mode encodings
    localparam logic [1:0] QMTU_MODE_SYSCLK = 2'h0;
    localparam logic [1:0] QMTU_MODE_GPIO_EDGE = 2'h1;
    localparam logic [1:0] QMTU_MODE_PULSE = 2'h2;
    localparam logic [1:0] QMTU_MODE_TICK = 2'h3;
    // =====================================================================
    // Counter values: reset, maximum and increment
    localparam logic [31:0] QMTU_TICK_RESET = 32'h0000_0000;
    localparam logic [31:0] QMTU_TICK_MAX = 32'hFFFF_FFFF;
    localparam logic [31:0] QMTU_TICK_ONE = 32'h0000_0001;
    typedef enum logic [1:0] {QMTU_PW_IDLE, QMTU_PW_ARMED, QMTU_PW_COUNT, QMTU_PW_DONE} qmtu_pw_e;
endpackage
`default_nettype wire

/* qmtu_timer.sv */
// One timer channel with four counting modes and an optional watchdog.
`default_nettype none
module qmtu_timer
    import qmtu_pkg::*;
#(
    parameter bit WDOG_CAPABLE = 1'b0
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic soft_reset,
    input wire logic [1:0] mode,
    input wire logic watchdog_en,
    input wire logic [qmtu_pkg::QMTU_WIDTH-1:0] init_tick,
    input wire logic [qmtu_pkg::QMTU_WIDTH-1:0] compare,
    input wire logic gpio,
    // Status
    output logic [qmtu_pkg::QMTU_WIDTH-1:0] tick,
    output logic irq,
    output logic match_status,
    output logic chip_reset
);
    // =====================================================================
    // Edge detection and control
    logic gpio_q;
    logic enable_q;
    logic gpio_rise;
    logic gpio_fall;
    logic start;
    logic hit;
    qmtu_pw_e pw_state;

    assign gpio_rise = gpio && !gpio_q;
    assign gpio_fall = !gpio && gpio_q;
    assign start = enable && !enable_q;
    assign hit = (tick == compare);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpio_q <= 1'b0;
            enable_q <= 1'b0;
        end
        else if (soft_reset)
        begin
            gpio_q <= 1'b0;
            enable_q <= 1'b0;
        end
        else
        begin
            gpio_q <= gpio;
            enable_q <= enable;
        end
    end

    // =====================================================================
    // Pulse-width sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pw_state <= QMTU_PW_IDLE;
        else if (soft_reset || !enable || mode != QMTU_MODE_PULSE)
            pw_state <= QMTU_PW_IDLE;
        else
        begin
            case (pw_state)
                QMTU_PW_IDLE: pw_state <= QMTU_PW_ARMED;
                QMTU_PW_ARMED: if (gpio_rise) pw_state <= QMTU_PW_COUNT; // see RULE_06
                QMTU_PW_COUNT: if (gpio_fall) pw_state <= QMTU_PW_DONE; // see RULE_16
                QMTU_PW_DONE: pw_state <= QMTU_PW_DONE;
                default: pw_state <= QMTU_PW_IDLE;
            endcase
        end
    end

    // =====================================================================
    // Tick counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tick <= QMTU_TICK_RESET;
        else if (soft_reset)
            tick <= QMTU_TICK_RESET; // see RULE_14
        else if (start)
            tick <= init_tick;
        else if (enable) // see RULE_12
        begin
            case (mode)
                QMTU_MODE_SYSCLK: tick <= hit ? QMTU_TICK_RESET : tick + QMTU_TICK_ONE; // see RULE_02 RULE_03 RULE_10
                QMTU_MODE_GPIO_EDGE:
                    if (hit)
                        tick <= QMTU_TICK_RESET; // see RULE_05 RULE_10
                    else if (gpio_rise)
                        tick <= tick + QMTU_TICK_ONE; // see RULE_04
                QMTU_MODE_PULSE:
                    if (pw_state == QMTU_PW_COUNT && !gpio_fall)
                        tick <= tick + QMTU_TICK_ONE; // see RULE_06
                QMTU_MODE_TICK: tick <= tick + QMTU_TICK_ONE; // see RULE_08 RULE_09
                default: tick <= tick;
            endcase
        end
    end

    // =====================================================================
    // Interrupt, status and watchdog
    // The watchdog reset is held until the system reset or the timer's soft_reset clears it, so it cannot be missed.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
            match_status <= 1'b0;
            chip_reset <= 1'b0;
        end
        else if (soft_reset)
        begin
            irq <= 1'b0;
            match_status <= 1'b0;
            chip_reset <= 1'b0;
        end
        else
        begin
            irq <= 1'b0;
            if (enable && !start)
            begin
                if (mode == QMTU_MODE_SYSCLK && hit)
                begin
                    if (WDOG_CAPABLE && watchdog_en)
                        chip_reset <= 1'b1; // see RULE_11 RULE_17
                    else
                        irq <= 1'b1; // see RULE_03
                    match_status <= 1'b1;
                end
                if (mode == QMTU_MODE_GPIO_EDGE && hit)
                    irq <= 1'b1; // see RULE_05
                if (mode == QMTU_MODE_PULSE && pw_state == QMTU_PW_COUNT && gpio_fall)
                    irq <= 1'b1; // see RULE_07
            end
        end
    end

    // =====================================================================
    // Checks
    tick_mode_no_irq_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_08
        (mode == QMTU_MODE_TICK && $stable(mode)) |=> !irq)
        else $error("Interrupt raised in tick mode.");
    sysclk_clear_a: assert property (@(posedge clk) disable iff (!rst_n || soft_reset) // see RULE_03
        (enable && !start && mode == QMTU_MODE_SYSCLK && hit) |=> (tick == QMTU_TICK_RESET))
        else $error("Counter not cleared on compare match.");
    sysclk_incr_a: assert property (@(posedge clk) disable iff (!rst_n || soft_reset) // see RULE_02
        (enable && !start && mode == QMTU_MODE_SYSCLK && !hit) |=> (tick == $past(tick) + QMTU_TICK_ONE))
        else $error("Counter did not advance by one.");
    disabled_hold_a: assert property (@(posedge clk) disable iff (!rst_n || soft_reset) // see RULE_12
        (!enable && !start) |=> $stable(tick))
        else $error("Counter moved while disabled.");
    tick_wrap_a: assert property (@(posedge clk) disable iff (!rst_n || soft_reset) // see RULE_09
        (enable && !start && mode == QMTU_MODE_TICK && tick == QMTU_TICK_MAX) |=> (tick == QMTU_TICK_RESET))
        else $error("Tick counter did not wrap to zero.");
    pulse_hold_a: assert property (@(posedge clk) disable iff (!rst_n || soft_reset) // see RULE_16
        (pw_state == QMTU_PW_DONE && enable && mode == QMTU_MODE_PULSE) |=> $stable(tick))
        else $error("Pulse count moved after falling edge.");
    pulse_irq_a: assert property (@(posedge clk) disable iff (!rst_n || soft_reset) // see RULE_07
        (enable && !start && mode == QMTU_MODE_PULSE && pw_state == QMTU_PW_COUNT && gpio_fall) |=> irq)
        else $error("No interrupt at pulse end.");
    edge_hold_a: assert property (@(posedge clk) disable iff (!rst_n || soft_reset) // see RULE_04
        (enable && !start && mode == QMTU_MODE_GPIO_EDGE && !hit && !gpio_rise) |=> $stable(tick))
        else $error("Edge counter moved without an edge.");
    soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_14
        soft_reset |=> (tick == QMTU_TICK_RESET && !irq && !chip_reset))
        else $error("Software reset did not clear the timer.");
    cov_match_c: cover property (@(posedge clk) disable iff (!rst_n) irq && mode == QMTU_MODE_SYSCLK);
    cov_pulse_c: cover property (@(posedge clk) disable iff (!rst_n) pw_state == QMTU_PW_DONE);
    cov_wdog_c: cover property (@(posedge clk) disable iff (!rst_n) chip_reset);
endmodule // qmtu_timer
`default_nettype wire

/* qmtu_top.sv */
// Top of the quad-mode timer unit: three timers, reset synchroniser, output flops.
`default_nettype none
// =========================================================================
// How it works
// RULE_01: Three independent timers, each selectable into any of four modes.
// RULE_02: System-clock mode counts up by one per clock from initial value.
// RULE_03: System-clock mode on compare match interrupts, clears counter, updates status.
// RULE_04: GPIO edge mode counts each GPIO rising edge from initial value.
// RULE_05: GPIO edge mode on compare match interrupts and clears counter.
// RULE_06: Pulse mode waits for GPIO rise, then counts system clocks.
// RULE_07: Pulse mode interrupts on GPIO falling edge.
// RULE_08: Tick mode counts every clock and never interrupts.
// RULE_09: Tick mode wraps from all ones back to zero.
// RULE_10: Compare modes reload from zero and interrupt on every match; a watchdog match on the third timer raises chip reset, not an interrupt.
// RULE_11: Only the third timer offers a watchdog that resets the chip.
// RULE_12: No timer counts until firmware enables it.
// RULE_13: Firmware should load initial tick of zero before enabling.
// RULE_14: Software reset bit returns a timer to its default state.
// RULE_15: Counters and compare values are thirty-two bits wide.
// RULE_16: Pulse mode holds count after falling edge until restart.
// RULE_17: Watchdog match asserts chip reset instead of an interrupt.
module qmtu_top
    import qmtu_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Per-timer control and the shared watchdog enable
    input wire logic [qmtu_pkg::QMTU_NUM_TIMERS-1:0] timer_enable,
    input wire logic [qmtu_pkg::QMTU_NUM_TIMERS-1:0] timer_soft_reset,
    input wire logic [2*qmtu_pkg::QMTU_NUM_TIMERS-1:0] timer_mode,
    input wire logic [qmtu_pkg::QMTU_NUM_TIMERS*qmtu_pkg::QMTU_WIDTH-1:0] timer_init_tick,
    input wire logic [qmtu_pkg::QMTU_NUM_TIMERS*qmtu_pkg::QMTU_WIDTH-1:0] timer_compare,
    input wire logic [qmtu_pkg::QMTU_NUM_TIMERS-1:0] timer_gpio,
    input wire logic watchdog_en,
    // Status
    output logic [qmtu_pkg::QMTU_NUM_TIMERS*qmtu_pkg::QMTU_WIDTH-1:0] timer_tick,
    output logic [qmtu_pkg::QMTU_NUM_TIMERS-1:0] timer_irq,
    output logic [qmtu_pkg::QMTU_NUM_TIMERS-1:0] timer_match_status,
    output logic chip_reset
);
    // =====================================================================
    // Reset release
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // =====================================================================
    // Timer channels
    // Wide port buses are used instead of arrays to keep the top plain for any bench.
    logic [QMTU_NUM_TIMERS*QMTU_WIDTH-1:0] tick_w;
    logic [QMTU_NUM_TIMERS-1:0] irq_w;
    logic [QMTU_NUM_TIMERS-1:0] status_w;
    logic [QMTU_NUM_TIMERS-1:0] wdog_w;

    for (genvar i = 0; i < QMTU_NUM_TIMERS; i++)
    begin : g_timer
        qmtu_timer #(
            .WDOG_CAPABLE(i == QMTU_WDOG_INDEX) // see RULE_11
        ) u_timer (
            .clk(clk),
            .rst_n(rst_n),
            .enable(timer_enable[i]),
            .soft_reset(timer_soft_reset[i]), // see RULE_14
            .mode(timer_mode[2*i +: 2]), // see RULE_01
            .watchdog_en(watchdog_en),
            .init_tick(timer_init_tick[QMTU_WIDTH*i +: QMTU_WIDTH]), // see RULE_15
            .compare(timer_compare[QMTU_WIDTH*i +: QMTU_WIDTH]),
            .gpio(timer_gpio[i]),
            .tick(tick_w[QMTU_WIDTH*i +: QMTU_WIDTH]),
            .irq(irq_w[i]),
            .match_status(status_w[i]),
            .chip_reset(wdog_w[i])
        );
    end

    // =====================================================================
    // Output registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_tick <= '0;
            timer_irq <= '0;
            timer_match_status <= '0;
            chip_reset <= 1'b0;
        end
        else
        begin
            timer_tick <= tick_w;
            timer_irq <= irq_w;
            timer_match_status <= status_w;
            chip_reset <= |wdog_w; // see RULE_17
        end
    end

    wdog_only_third_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_11
        (wdog_w[0] == 1'b0 && wdog_w[1] == 1'b0))
        else $error("Watchdog reset from a timer other than the third.");
    irq_follows_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_03
        irq_w[0] |=> timer_irq[0])
        else $error("Interrupt output lags more than one cycle.");
    cov_all_irq_c: cover property (@(posedge clk) disable iff (!rst_n) &timer_irq);
endmodule // qmtu_top
`default_nettype wire

/* quad_mode_timer_unit_test.sv */
// Self-checking testbench for the quad-mode timer unit with a cycle model of all three timers.
`default_nettype none
module quad_mode_timer_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    import qmtu_pkg::*;
    // =====================================================================
    // Signals and model state
    logic clk;
    logic reset_n;
    logic watchdog_en;
    logic [2:0] timer_enable;
    logic [2:0] timer_soft_reset;
    logic [2:0] timer_gpio;
    logic [5:0] timer_mode;
    logic [95:0] timer_init_tick;
    logic [95:0] timer_compare;
    wire logic [95:0] timer_tick;
    wire logic [2:0] timer_irq;
    wire logic [2:0] timer_match_status;
    wire logic chip_reset;
    logic [31:0] m_tick [3];
    logic [31:0] p_tick [3];
    logic m_irq [3];
    logic p_irq [3];
    logic m_st [3];
    logic p_st [3];
    logic en_q [3];
    logic g_q [3];
    int pw [3];
    logic m_cr;
    logic p_cr;
    bit run;
    int miscompares;
    int n_compared;
    qmtu_top dut (.clk(clk), .reset_n(reset_n), .timer_enable(timer_enable), .timer_soft_reset(timer_soft_reset),
        .timer_mode(timer_mode), .timer_init_tick(timer_init_tick), .timer_compare(timer_compare),
        .timer_gpio(timer_gpio), .watchdog_en(watchdog_en), .timer_tick(timer_tick), .timer_irq(timer_irq),
        .timer_match_status(timer_match_status), .chip_reset(chip_reset));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // =====================================================================
    // Checking and closing
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d.", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // =====================================================================
    // Cycle model: internal state moves on each edge, the ports show it one edge later.
    task automatic model_step(input int i);
        logic en;
        logic g;
        logic [1:0] md;
        logic [31:0] cmp;
        en = timer_enable[i];
        g = timer_gpio[i];
        md = timer_mode[2*i +: 2];
        cmp = timer_compare[32*i +: 32];
        m_irq[i] = 1'b0;
        if (timer_soft_reset[i])
        begin
            m_tick[i] = '0;
            m_st[i] = 1'b0;
            pw[i] = 0;
            en = 1'b0;
            g = 1'b0;
            if (i == 2)
                m_cr = 1'b0;
        end
        else if (en && !en_q[i])
        begin
            m_tick[i] = timer_init_tick[32*i +: 32];
            pw[i] = 1;
        end
        else if (en)
        begin
            case (md)
                QMTU_MODE_SYSCLK, QMTU_MODE_GPIO_EDGE:
                    if (m_tick[i] == cmp)
                    begin
                        m_tick[i] = '0;
                        m_st[i] = m_st[i] | (md == QMTU_MODE_SYSCLK);
                        if (md == QMTU_MODE_SYSCLK && i == QMTU_WDOG_INDEX && watchdog_en)
                            m_cr = 1'b1;
                        else
                            m_irq[i] = 1'b1;
                    end
                    else if (md == QMTU_MODE_SYSCLK || (g && !g_q[i]))
                        m_tick[i] = m_tick[i] + 32'h1;
                QMTU_MODE_PULSE:
                    if (pw[i] == 1 && g && !g_q[i])
                        pw[i] = 2;
                    else if (pw[i] == 2 && !g && g_q[i])
                    begin
                        pw[i] = 3;
                        m_irq[i] = 1'b1;
                    end
                    else if (pw[i] == 2)
                        m_tick[i] = m_tick[i] + 32'h1;
                default:
                    m_tick[i] = m_tick[i] + 32'h1;
            endcase
        end
        en_q[i] = en;
        g_q[i] = g;
    endtask
    always @(posedge clk)
    begin
        if (run)
        begin
            p_cr = m_cr;
            for (int i = 0; i < 3; i++)
            begin
                p_tick[i] = m_tick[i];
                p_irq[i] = m_irq[i];
                p_st[i] = m_st[i];
                model_step(i);
            end
        end
    end
    always @(negedge clk)
    begin
        if (run)
        begin
            for (int i = 0; i < 3; i++)
            begin
                check("timer_tick", timer_tick[32*i +: 32], p_tick[i]);
                check("timer_irq", {31'h0, timer_irq[i]}, {31'h0, p_irq[i]});
                check("timer_match_status", {31'h0, timer_match_status[i]}, {31'h0, p_st[i]});
            end
            check("chip_reset", {31'h0, chip_reset}, {31'h0, p_cr});
        end
    end
    // =====================================================================
    // Stimulus
    task automatic run_random(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            // Slow toggling gives pulses of several clocks, not only one-cycle blips.
            timer_gpio = timer_gpio ^ 3'($urandom_range(0, 7) & $urandom_range(0, 7));
        end
    endtask
    initial
    begin
        reset_n = 1'b0;
        watchdog_en = 1'b0;
        timer_enable = 3'h0;
        timer_soft_reset = 3'h0;
        timer_gpio = 3'h0;
        timer_mode = 6'h00;
        timer_init_tick = '0;
        timer_compare = '0;
        run = 1'b0;
        miscompares = 0;
        n_compared = 0;
        m_cr = 1'b0;
        p_cr = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            m_tick[i] = '0;
            p_tick[i] = '0;
            m_irq[i] = 1'b0;
            p_irq[i] = 1'b0;
            m_st[i] = 1'b0;
            p_st[i] = 1'b0;
            en_q[i] = 1'b0;
            g_q[i] = 1'b0;
            pw[i] = 0;
        end
        void'($urandom(32'hC4FD));
        repeat (5) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 run = 1'b1;
        for (int m = 0; m < 5; m++)
        begin
            // Pass four repeats mode 0 with the third timer acting as watchdog.
            timer_mode = (m == 4) ? 6'h00 : {3{2'(m)}};
            watchdog_en = (m == 4);
            for (int i = 0; i < 3; i++)
            begin
                timer_compare[32*i +: 32] = 32'($urandom_range(1, 5));
                timer_init_tick[32*i +: 32] = (m == 3) ? 32'hFFFF_FFFD - 32'(i) : 32'h0;
            end
            run_random(6);
            timer_enable = 3'h7;
            run_random(30);
            timer_enable = 3'h0;
            run_random(1);
            timer_enable = 3'h7;
            run_random(30);
            timer_enable = 3'h0;
            timer_soft_reset = 3'h7;
            timer_gpio = 3'h0;
            run_random(0);
            @(posedge clk);
            #1 timer_soft_reset = 3'h0;
            repeat (3) @(posedge clk);
            #1;
        end
        wrap_up();
    end
endmodule // quad_mode_timer_unit_test
`default_nettype wire
